/* File: inc/fp_default_status_pkg.sv */
/*
 * Package for the floating-point default status bank and enable logic:
 * register addresses, field positions, reset values, access struct.
 * Assumes a core-side register port that presents one decoded access per cycle.
 */
`default_nettype none

package fp_default_status_pkg;

  // ****************************************************************
  // addresses
  // ****************************************************************
  localparam logic [31:0] CPAC_ADDR = 32'he000ed88;
  // no address is printed for the default status register; core-chosen
  localparam logic [31:0] FP_DEFAULT_STATUS_ADDR = 32'he000ef3c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ALT_HALF_BIT = 26;
  localparam int DNAN_BIT = 25;
  localparam int FTZ_BIT = 24;
  localparam int RND_LSB = 22;
  localparam int RND_MSB = 23;
  localparam int CP_EN_LSB = 20;
  localparam int CP_EN_MSB = 23;
  localparam logic [31:0] DFLT_MASK = 32'h07c00000;
  localparam logic [31:0] CP_EN_MASK = 32'h00f00000;
  localparam logic [3:0] CP_EN_ALL = 4'hf;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] DFLT_RESET = 32'h00000000;
  localparam logic [31:0] CPAC_RESET = 32'h00000000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic privileged;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic alt_half_precision;
    logic default_nan_select;
    logic flush_to_zero;
    logic [1:0] rounding_select;
  } fp_ctrl_t;

endpackage : fp_default_status_pkg

`default_nettype wire

/* File: logic/fp_default_bank.sv */
/*
 * One banked copy of the default status register; fields only, reserved bits dropped.
 * Assumes the parent decodes the address and security state.
 */
`timescale 1ns/1ps
`default_nettype none

module fp_default_bank (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [31:0] wdata_i,
  output var fp_default_status_pkg::fp_ctrl_t ctrl_o
);

  fp_default_status_pkg::fp_ctrl_t ctrl_reg;
  fp_default_status_pkg::fp_ctrl_t ctrl_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_en_i) begin
      ctrl_next.alt_half_precision = wdata_i[fp_default_status_pkg::ALT_HALF_BIT]; // [R4]
      ctrl_next.default_nan_select = wdata_i[fp_default_status_pkg::DNAN_BIT]; // [R5]
      ctrl_next.flush_to_zero = wdata_i[fp_default_status_pkg::FTZ_BIT]; // [R6]
      ctrl_next.rounding_select =
        wdata_i[fp_default_status_pkg::RND_MSB:fp_default_status_pkg::RND_LSB]; // [R7]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= fp_default_status_pkg::DFLT_RESET[fp_default_status_pkg::ALT_HALF_BIT:
                                                    fp_default_status_pkg::RND_LSB];
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctrl_o = ctrl_reg;

endmodule : fp_default_bank

`default_nettype wire

/* File: logic/fp_default_status_and_enable.sv */
/*
 * Default status register bank, live control/sticky flags and coprocessor enable.
 * Assumes the core presents register accesses with privilege, a security-state
 * level, context-creation and exception pulses, all synchronous to core_clk_i.
 */
// Operation
// [R1] default status register holds initial control values
// [R2] new context loads live controls from defaults
// [R3] banked secure and non-secure copies selected
// [R4] bit 26 default alternative half precision
// [R5] bit 25 default NaN control
// [R6] bit 24 default flush to zero
// [R7] bits 23:22 default rounding mode
// [R8] other bits read zero, writes ignored
// [R9] unit disabled after reset, access denied
// [R10] no floating-point execution while disabled
// [R11] access control register privileged only
// [R12] secure boot sets non-secure coprocessor access
// [R13] secure software sets context control
// [R14] enable only after secure setup done
// [R15] bits 20-23 all ones grant access
// [R16] barriers follow the access control write
// [R17] sticky divide-by-zero flag until cleared
// [R18] sticky invalid-operation flag until cleared
`timescale 1ns/1ps
`default_nettype none

module fp_default_status_and_enable (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire fp_default_status_pkg::reg_req_t req_i,
  input wire logic secure_state_i,
  input wire logic new_context_i,
  input wire logic live_wr_i,
  input wire fp_default_status_pkg::fp_ctrl_t live_wdata_i,
  input wire logic divide_zero_event_i,
  input wire logic invalid_op_event_i,
  input wire logic sticky_clear_i,
  input wire logic fp_issue_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic priv_fault_o,
  output logic fp_enabled_o,
  output logic fp_issue_ok_o,
  output logic fp_denied_o,
  output var fp_default_status_pkg::fp_ctrl_t live_ctrl_o,
  output logic divide_zero_sticky_o,
  output logic invalid_op_sticky_o
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic hit_dflt;
  logic hit_cpac;
  logic wr_dflt_s;
  logic wr_dflt_ns;
  fp_default_status_pkg::fp_ctrl_t dflt_s;
  fp_default_status_pkg::fp_ctrl_t dflt_ns;
  fp_default_status_pkg::fp_ctrl_t dflt_sel;

  assign hit_dflt = req_i.valid && req_i.addr == fp_default_status_pkg::FP_DEFAULT_STATUS_ADDR;
  // unprivileged accesses to the access control register are refused outright
  assign hit_cpac = req_i.valid && req_i.privileged &&
                    req_i.addr == fp_default_status_pkg::CPAC_ADDR; // [R11]
  assign wr_dflt_s = hit_dflt && req_i.write && secure_state_i; // [R3]
  assign wr_dflt_ns = hit_dflt && req_i.write && !secure_state_i; // [R3]
  assign dflt_sel = secure_state_i ? dflt_s : dflt_ns; // [R3]

  // ****************************************************************
  // banked defaults
  // ****************************************************************
  fp_default_bank u_bank_secure (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_dflt_s),
    .wdata_i(req_i.wdata),
    .ctrl_o(dflt_s)
  ); // [R1]

  fp_default_bank u_bank_nonsecure (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_dflt_ns),
    .wdata_i(req_i.wdata),
    .ctrl_o(dflt_ns)
  ); // [R1]

  function automatic logic [31:0] pack_dflt(input fp_default_status_pkg::fp_ctrl_t c);
    logic [31:0] v;
    v = '0;
    v[fp_default_status_pkg::ALT_HALF_BIT] = c.alt_half_precision;
    v[fp_default_status_pkg::DNAN_BIT] = c.default_nan_select;
    v[fp_default_status_pkg::FTZ_BIT] = c.flush_to_zero;
    v[fp_default_status_pkg::RND_MSB:fp_default_status_pkg::RND_LSB] = c.rounding_select;
    return v;
  endfunction : pack_dflt

  // ****************************************************************
  // access control, live state, read port
  // ****************************************************************
  logic [31:0] cpac_reg;
  logic [31:0] cpac_next;
  fp_default_status_pkg::fp_ctrl_t live_reg;
  fp_default_status_pkg::fp_ctrl_t live_next;
  logic dz_reg;
  logic dz_next;
  logic io_reg;
  logic io_next;
  logic [31:0] rdata_next;
  logic rvalid_next;
  logic fault_next;
  logic enabled;
  logic issue_ok_next;
  logic denied_next;

  // only the coprocessor fields are implemented; the rest reads zero
  assign enabled = cpac_reg[fp_default_status_pkg::CP_EN_MSB:fp_default_status_pkg::CP_EN_LSB]
                   == fp_default_status_pkg::CP_EN_ALL; // [R15]

  always_comb begin
    cpac_next = cpac_reg;
    if (hit_cpac && req_i.write) begin
      cpac_next = req_i.wdata & fp_default_status_pkg::CP_EN_MASK; // [R15]
    end

    live_next = live_reg;
    if (new_context_i) begin
      live_next = dflt_sel; // [R2]
    end else if (live_wr_i) begin
      live_next = live_wdata_i;
    end

    // set wins over a clear in the same cycle
    dz_next = divide_zero_event_i || (dz_reg && !sticky_clear_i); // [R17]
    io_next = invalid_op_event_i || (io_reg && !sticky_clear_i); // [R18]

    rdata_next = '0;
    rvalid_next = 1'b0;
    fault_next = 1'b0;
    if (req_i.valid && !req_i.write) begin
      if (hit_dflt) begin
        rdata_next = pack_dflt(dflt_sel) & fp_default_status_pkg::DFLT_MASK; // [R8]
        rvalid_next = 1'b1;
      end else if (hit_cpac) begin
        rdata_next = cpac_reg;
        rvalid_next = 1'b1;
      end
    end
    if (req_i.valid && !req_i.privileged && req_i.addr == fp_default_status_pkg::CPAC_ADDR) begin
      fault_next = 1'b1; // [R11]
    end

    // instructions only proceed once both coprocessors are granted
    issue_ok_next = fp_issue_i && enabled; // [R10]
    denied_next = fp_issue_i && !enabled; // [R10]
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cpac_reg <= fp_default_status_pkg::CPAC_RESET; // [R9]
      live_reg <= '0;
      dz_reg <= 1'b0;
      io_reg <= 1'b0;
      rdata_o <= '0;
      rvalid_o <= 1'b0;
      priv_fault_o <= 1'b0;
      fp_issue_ok_o <= 1'b0;
      fp_denied_o <= 1'b0;
      fp_enabled_o <= 1'b0;
    end else begin
      cpac_reg <= cpac_next;
      live_reg <= live_next;
      dz_reg <= dz_next;
      io_reg <= io_next;
      rdata_o <= rdata_next;
      rvalid_o <= rvalid_next;
      priv_fault_o <= fault_next;
      fp_issue_ok_o <= issue_ok_next;
      fp_denied_o <= denied_next;
      fp_enabled_o <= cpac_next[fp_default_status_pkg::CP_EN_MSB:fp_default_status_pkg::CP_EN_LSB]
                      == fp_default_status_pkg::CP_EN_ALL;
    end
  end

  assign live_ctrl_o = live_reg;
  assign divide_zero_sticky_o = dz_reg;
  assign invalid_op_sticky_o = io_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ctx_load_default: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R2]
    new_context_i |=> live_ctrl_o == $past(dflt_sel))
    else $error("live controls not loaded from defaults");
  a_reset_disabled: assert property (@(posedge core_clk_i) // [R9]
    !rst_n_i |=> !fp_enabled_o && !fp_issue_ok_o)
    else $error("unit enabled after reset");
  a_no_issue_disabled: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R10]
    fp_issue_i && !enabled |=> fp_denied_o && !fp_issue_ok_o)
    else $error("issue allowed while disabled");
  a_unpriv_no_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R11]
    req_i.valid && !req_i.privileged |=> $stable(cpac_reg))
    else $error("unprivileged write changed access control");
  a_grant_full: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R15]
    hit_cpac && req_i.write && req_i.wdata[23:20] == 4'hf |=> fp_enabled_o)
    else $error("all-ones write did not enable");
  a_dz_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R17]
    divide_zero_event_i |=> divide_zero_sticky_o ##1 (divide_zero_sticky_o || $past(sticky_clear_i)))
    else $error("divide-by-zero flag lost");
  a_io_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R18]
    io_reg && !sticky_clear_i && !invalid_op_event_i |=> invalid_op_sticky_o)
    else $error("invalid-op flag dropped");
  a_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R8]
    rvalid_o && $past(hit_dflt) |-> (rdata_o & ~fp_default_status_pkg::DFLT_MASK) == 32'h0)
    else $error("reserved default bits not zero");
  a_bank_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
    wr_dflt_s |=> $stable(dflt_ns))
    else $error("secure write reached non-secure copy");

  // ****************************************************************
  // checks: banked fields and read port
  // ****************************************************************
  a_bank_ns_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
    wr_dflt_ns
    |=> $stable(dflt_s))
    else $error("non-secure write reached secure copy");
  a_field_alt_half: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R4]
    wr_dflt_s
    |=> dflt_s.alt_half_precision == $past(req_i.wdata[fp_default_status_pkg::ALT_HALF_BIT]))
    else $error("half-precision default not stored");
  a_field_dnan: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R5]
    wr_dflt_ns
    |=> dflt_ns.default_nan_select == $past(req_i.wdata[fp_default_status_pkg::DNAN_BIT]))
    else $error("default NaN default not stored");
  a_field_ftz: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R6]
    wr_dflt_s
    |=> dflt_s.flush_to_zero == $past(req_i.wdata[fp_default_status_pkg::FTZ_BIT]))
    else $error("flush-to-zero default not stored");
  a_field_rounding: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R7]
    wr_dflt_ns
    |=> dflt_ns.rounding_select == $past(req_i.wdata[fp_default_status_pkg::RND_MSB:fp_default_status_pkg::RND_LSB]))
    else $error("rounding default not stored");
  a_read_answer: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R1]
    hit_dflt && !req_i.write
    |=> rvalid_o)
    else $error("default status read not answered");
  a_rdata_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R8]
    !rvalid_o
    |-> rdata_o == 32'h0)
    else $error("read data not zero between answers");
  a_cpac_rsvd_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R15]
    rvalid_o && $past(hit_cpac)
    |-> (rdata_o & ~fp_default_status_pkg::CP_EN_MASK) == 32'h0)
    else $error("access control unused bits not zero");
  a_fault_no_answer: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R11]
    req_i.valid && !req_i.privileged && req_i.addr == fp_default_status_pkg::CPAC_ADDR
    |=> priv_fault_o && !rvalid_o)
    else $error("unprivileged access control access not refused");

  // ****************************************************************
  // checks: access control and issue
  // ****************************************************************
  a_partial_no_grant: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R15]
    hit_cpac && req_i.write && req_i.wdata[fp_default_status_pkg::CP_EN_MSB:fp_default_status_pkg::CP_EN_LSB] != 4'hf
    |=> !fp_enabled_o)
    else $error("partial grant enabled the unit");
  a_issue_granted: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R10]
    fp_issue_i && enabled
    |=> fp_issue_ok_o && !fp_denied_o)
    else $error("issue refused while enabled");
  a_issue_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R10]
    !fp_issue_i
    |=> !fp_issue_ok_o && !fp_denied_o)
    else $error("issue answer without a request");

  // ****************************************************************
  // checks: context load and sticky flags
  // ****************************************************************
  a_ctx_secure_bank: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
    new_context_i && secure_state_i
    |=> live_ctrl_o == $past(dflt_s))
    else $error("secure context not loaded from secure copy");
  a_ctx_nonsecure_bank: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R3]
    new_context_i && !secure_state_i
    |=> live_ctrl_o == $past(dflt_ns))
    else $error("non-secure context not loaded from non-secure copy");
  a_ctx_priority: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R2]
    new_context_i && live_wr_i
    |=> live_ctrl_o == $past(dflt_sel))
    else $error("live write beat the context load");
  a_dz_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R17]
    dz_reg && !sticky_clear_i && !divide_zero_event_i
    |=> divide_zero_sticky_o)
    else $error("divide-by-zero flag dropped");
  a_dz_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R17]
    sticky_clear_i && !divide_zero_event_i
    |=> !divide_zero_sticky_o)
    else $error("divide-by-zero flag not cleared");
  a_io_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R18]
    invalid_op_event_i
    |=> invalid_op_sticky_o)
    else $error("invalid-op flag not set");
  a_io_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R18]
    sticky_clear_i && !invalid_op_event_i
    |=> !invalid_op_sticky_o)
    else $error("invalid-op flag not cleared");

endmodule : fp_default_status_and_enable

`default_nettype wire

/* File: test/test_fp_default_status_and_enable.sv */
/*
 * Self-checking bench for the default status bank and coprocessor enable block.
 * Assumes the block answers registered, at the edge that takes an input, one cycle after it is driven.
 */
`timescale 1ns/1ps
`default_nettype none

module test_fp_default_status_and_enable;
  logic core_clk_i, rst_n_i, secure, new_ctx, live_wr, dz_ev, io_ev, clr, issue;
  fp_default_status_pkg::reg_req_t req;
  fp_default_status_pkg::fp_ctrl_t live_wdata, live_ctrl;
  logic [31:0] rdata, seed, d;
  logic [31:0] bank [2];
  logic rvalid, pfault, en, iss_ok, denied, dz, io, s;
  int failures, n_tests;

  fp_default_status_and_enable fp_default_status_and_enable_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req), .secure_state_i(secure),
    .new_context_i(new_ctx), .live_wr_i(live_wr), .live_wdata_i(live_wdata),
    .divide_zero_event_i(dz_ev), .invalid_op_event_i(io_ev), .sticky_clear_i(clr),
    .fp_issue_i(issue), .rdata_o(rdata), .rvalid_o(rvalid), .priv_fault_o(pfault),
    .fp_enabled_o(en), .fp_issue_ok_o(iss_ok), .fp_denied_o(denied), .live_ctrl_o(live_ctrl),
    .divide_zero_sticky_o(dz), .invalid_op_sticky_o(io)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // drive 1 ns after the edge so every output sampled is settled
  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic acc(input logic w, input logic p, input logic [31:0] a, input logic [31:0] wd);
    step();
    req = '{1'b1, w, p, a, wd};
    step();
    req = '0;
  endtask : acc

  task automatic rd(input logic p, input logic [31:0] a, input logic ok, input logic [31:0] exp);
    acc(1'b0, p, a, 32'h0);
    chk("rvalid", {31'h0, rvalid}, {31'h0, ok});
    chk("rdata", rdata, exp);
  endtask : rd

  task automatic iss(input logic ok);
    step();
    issue = 1'b1;
    step();
    issue = 1'b0;
    chk("issue ok", {31'h0, iss_ok}, {31'h0, ok});
    chk("denied", {31'h0, denied}, {31'h0, !ok});
  endtask : iss

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // clock, reset, watchdog
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // whole sequence is about 125 cycles; generous margin
  initial begin
    repeat (5000) @(posedge core_clk_i);
    failures++;
    close_out();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst_n_i, secure, new_ctx, live_wr, dz_ev, io_ev, clr, issue} = '0;
    req = '0;
    live_wdata = '0;
    seed = 32'h0000a844;
    failures = 0;
    n_tests = 0;
    bank[0] = 32'h0;
    bank[1] = 32'h0;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    chk("enabled", {31'h0, en}, 32'h0);
    rd(1'b1, fp_default_status_pkg::CPAC_ADDR, 1'b1, 32'h0);
    iss(1'b0);
    acc(1'b1, 1'b0, fp_default_status_pkg::CPAC_ADDR, fp_default_status_pkg::CP_EN_MASK);
    chk("fault", {31'h0, pfault}, 32'h1);
    chk("enabled", {31'h0, en}, 32'h0);
    rd(1'b0, fp_default_status_pkg::CPAC_ADDR, 1'b0, 32'h0);
    acc(1'b1, 1'b1, fp_default_status_pkg::CPAC_ADDR, 32'h00e00000);
    chk("enabled", {31'h0, en}, 32'h0);
    iss(1'b0);
    // in secure state, read back the access control value, then write it with bits 20-23 set to enable
    secure = 1'b1;
    rd(1'b1, fp_default_status_pkg::CPAC_ADDR, 1'b1, 32'h00e00000);
    acc(1'b1, 1'b1, fp_default_status_pkg::CPAC_ADDR, rdata | rnd() | fp_default_status_pkg::CP_EN_MASK);
    chk("enabled", {31'h0, en}, 32'h1);
    secure = 1'b0;
    // idle cycles stand in for the two barriers
    repeat (2) step();
    rd(1'b1, fp_default_status_pkg::CPAC_ADDR, 1'b1, fp_default_status_pkg::CP_EN_MASK);
    iss(1'b1);
    rd(1'b1, 32'he000ef40, 1'b0, 32'h0); // unmapped: ignored
    // banked defaults: all-ones corner first, then random words and privilege
    for (int i = 0; i < 10; i++) begin
      s = i[0];
      d = (i < 2) ? 32'hffffffff : rnd();
      secure = s;
      acc(1'b1, rnd() % 2 == 0, fp_default_status_pkg::FP_DEFAULT_STATUS_ADDR, d);
      bank[s] = d & fp_default_status_pkg::DFLT_MASK;
      secure = 1'b0;
      rd(1'b1, fp_default_status_pkg::FP_DEFAULT_STATUS_ADDR, 1'b1, bank[0]);
      secure = 1'b1;
      rd(1'b1, fp_default_status_pkg::FP_DEFAULT_STATUS_ADDR, 1'b1, bank[1]);
      step();
      s = rnd() % 2;
      secure = s;
      new_ctx = 1'b1;
      live_wr = i[0];
      d = rnd();
      live_wdata = d[4:0];
      step();
      {new_ctx, live_wr} = 2'b00;
      chk("live", {27'h0, live_ctrl}, {27'h0, bank[s][26:22]});
    end
    // plain live write without a context load
    step();
    d = rnd();
    live_wr = 1'b1;
    live_wdata = d[4:0];
    step();
    live_wr = 1'b0;
    chk("live write", {27'h0, live_ctrl}, {27'h0, d[4:0]});
    // sticky flags: set, clear racing a set, plain clear
    step();
    dz_ev = 1'b1;
    step();
    dz_ev = 1'b0;
    repeat (3) step();
    chk("sticky", {30'h0, dz, io}, 32'h2);
    {io_ev, clr} = 2'b11;
    step();
    {io_ev, clr} = 2'b00;
    chk("sticky", {30'h0, dz, io}, 32'h1);
    clr = 1'b1;
    step();
    clr = 1'b0;
    chk("sticky", {30'h0, dz, io}, 32'h0);
    // mid-run reset: unit disabled again, banks back to zero
    rst_n_i = 1'b0;
    repeat (2) step();
    rst_n_i = 1'b1;
    chk("enabled", {31'h0, en}, 32'h0);
    rd(1'b1, fp_default_status_pkg::CPAC_ADDR, 1'b1, 32'h0);
    secure = 1'b1;
    rd(1'b1, fp_default_status_pkg::FP_DEFAULT_STATUS_ADDR, 1'b1, 32'h0);
    secure = 1'b0;
    rd(1'b1, fp_default_status_pkg::FP_DEFAULT_STATUS_ADDR, 1'b1, 32'h0);
    close_out();
  end
endmodule : test_fp_default_status_and_enable

`default_nettype wire
